// ==== pkg/pvc_pkg.sv ====
// Package: constants and carrier types of the process value conditioning block
package pvc_pkg;

   // ==========================================================
   // Clock and time
   localparam int CLK_HZ = 25_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
   localparam int DISC_RTD4_MS = 5000;
   localparam int DISC_MV_MS = 1000;
   localparam int DISC_OTHER_MS = 500;
   localparam int DLY_MAX_S = 60;
   localparam int IVL_MAX_S = 16;

   // ==========================================================
   // Value scale: 0.01 % of range, 0 = 0 %, 16'h2710 = 100 %
   localparam logic [15:0] PCT_P115 = 16'h2cec;
   localparam logic [15:0] PCT_M15 = 16'hfa24;
   localparam logic [15:0] PCT_P1075 = 16'h29fe;
   localparam logic [15:0] PCT_M075 = 16'hfd12;
   localparam logic [15:0] PCT_MID = 16'h1388;
   localparam int DROP_PCT = 7;
   localparam int PCT_DEN = 100;

   // ==========================================================
   // Register map (byte addresses, 12-bit bus address)
   localparam logic [11:0] IRQ_STAT_ADR = 12'h000;
   localparam logic [11:0] IRQ_MASK_ADR = 12'h004;
   localparam logic [3:0] CH_PAGE = 4'h1;
   localparam logic [5:0] OFS_CFG = 6'h00;
   localparam logic [5:0] OFS_SCALE = 6'h04;
   localparam logic [5:0] OFS_SP0 = 6'h08;
   localparam logic [5:0] OFS_SP5 = 6'h1c;
   localparam logic [5:0] OFS_HYS = 6'h20;
   localparam logic [5:0] OFS_PV = 6'h24;
   localparam logic [5:0] OFS_RATE = 6'h28;
   localparam logic [5:0] OFS_STAT = 6'h2c;
   localparam int IRQ_W = 9;
   localparam int IRQ_OVR_BIT = 8;

   // ==========================================================
   // Reset values and configuration write mask
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [31:0] CFG_WMASK = 32'h007f_1f3f;
   localparam logic [31:0] SCALE_RST = 32'h0000_2710;
   localparam logic [15:0] SP_HI_RST = 16'h7fff;
   localparam logic [15:0] SP_LO_RST = 16'h8000;

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      IN_RTD3 = 4'h0, IN_RTD4 = 4'h1, IN_TC = 4'h2, IN_MV100 = 4'h3,
      IN_POT = 4'h4, IN_MA4_20 = 4'h5, IN_V1_5 = 4'h6, IN_UNI_V = 4'h7,
      IN_MA0_20 = 4'h8, IN_BIP_V = 4'h9
   } pvc_in_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1, ST_DIV = 4'h2, ST_SQRT = 4'h4, ST_POST = 4'h8
   } pvc_state_t;

   typedef struct packed {
      logic [8:0] rsvd_hi;
      logic [6:0] avg_nm1;
      logic [2:0] rsvd_mid;
      logic [4:0] rate_ivl;
      logic [1:0] rsvd_lo;
      logic sqrt_en;
      logic clamp_hi;
      logic [3:0] in_type;
   } pvc_cfg_t;

   typedef struct packed {
      logic valid;
      logic [1:0] ch;
      logic disc;
      logic [15:0] value;
   } pvc_smp_t;

endpackage : pvc_pkg

// ==== hw/pvc_top.sv ====
// Process value conditioning: fault, clamp, average, root, rate, alarms
//
// Chosen here: the Wishbone register port and the register offsets.
module pvc_top #(
   parameter logic [15:0] MS_CYCLES = 16'(pvc_pkg::MS_CYCLES_DEF)
) (
   // Clock, reset, enable
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic CE,
   // Classic Wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [11:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // Conversion results
   input wire pvc_pkg::pvc_smp_t SMP,
   // Status
   output logic [3:0] CH_FAULT,
   output logic IRQ
);

   // ==========================================================
   // State
   typedef struct packed {
      pvc_pkg::pvc_state_t st;
      logic ack;
      logic [31:0] rdat;
      logic [8:0] irq_stat;
      logic [8:0] irq_mask;
      pvc_pkg::pvc_cfg_t [3:0] cfg;
      logic [3:0][31:0] scale;
      logic [3:0][5:0][15:0] sp;
      logic [3:0][15:0] hys;
      logic [3:0][5:0] dly;
      logic [3:0][15:0] pv;
      logic [3:0][15:0] rate;
      logic [3:0][15:0] ref_pv;
      logic [3:0] fault;
      logic [3:0] disc_raw;
      logic [3:0][12:0] disc_cnt;
      logic [3:0][13:0] rate_cnt;
      logic [3:0][5:0] alm;
      logic [3:0][5:0][15:0] alm_cnt;
      logic [15:0] tick_cnt;
      logic tick;
      logic [3:0][127:0][15:0] hist;
      logic [3:0][6:0] wp;
      logic [3:0][23:0] sum;
      logic [1:0] ch;
      logic [15:0] x;
      logic [8:0] rem;
      logic [23:0] quo;
      logic neg;
      logic [4:0] itr;
      logic [33:0] rad;
      logic [16:0] root;
   } pvc_regs_t;

   pvc_regs_t r;
   pvc_regs_t n;

   // ==========================================================
   // Helpers
   function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
      return $signed(a) > $signed(b);
   endfunction : sgt

   function automatic logic [31:0] bmerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return (old & ~m) | (nw & m);
   endfunction : bmerge

   function automatic logic alm_want(input logic [15:0] v,
      input logic [15:0] sp, input logic [15:0] hys, input logic hi,
      input logic cur);
      logic signed [17:0] sv;
      logic signed [17:0] thr;
      sv = $signed({{2{v[15]}}, v});
      thr = $signed({{2{sp[15]}}, sp});
      // Active alarm releases only past the hysteresis band
      if (cur && hi) begin
         thr = thr - $signed({2'b00, hys});
      end else if (cur) begin
         thr = thr + $signed({2'b00, hys});
      end
      return hi ? (sv > thr) : (sv < thr);
   endfunction : alm_want

   function automatic logic range_fault(input logic [3:0] t,
      input logic [15:0] v);
      if (t == pvc_pkg::IN_MA0_20) begin
         return sgt(v, pvc_pkg::PCT_P115);
      end else if (t == pvc_pkg::IN_BIP_V) begin
         return sgt(v, pvc_pkg::PCT_P1075) || sgt(pvc_pkg::PCT_M075, v);
      end else begin
         return sgt(v, pvc_pkg::PCT_P115) || sgt(pvc_pkg::PCT_M15, v);
      end
   endfunction : range_fault

   function automatic logic [15:0] clamp_val(input logic [3:0] t,
      input logic hi);
      if (t <= pvc_pkg::IN_POT) begin
         return hi ? pvc_pkg::PCT_P115 : pvc_pkg::PCT_M15;
      end else if (t == pvc_pkg::IN_MA4_20 || t == pvc_pkg::IN_V1_5) begin
         return pvc_pkg::PCT_M15;
      end else if (t == pvc_pkg::IN_BIP_V) begin
         return pvc_pkg::PCT_MID;
      end else begin
         return 16'h0000;
      end
   endfunction : clamp_val

   function automatic logic [12:0] disc_lim(input logic [3:0] t);
      if (t == pvc_pkg::IN_RTD4) begin
         return 13'(pvc_pkg::DISC_RTD4_MS);
      end else if (t == pvc_pkg::IN_MV100) begin
         return 13'(pvc_pkg::DISC_MV_MS);
      end else begin
         return 13'(pvc_pkg::DISC_OTHER_MS);
      end
   endfunction : disc_lim

   // ==========================================================
   // Next-state logic
   logic [1:0] c;
   logic [1:0] bc;
   logic [3:0] bidx;
   logic wb_go;
   logic [31:0] wdat;
   logic [8:0] irq_clr;
   logic [8:0] irq_ev;
   logic dconf;
   logic [7:0] nlen;
   logic [15:0] xin;
   logic [15:0] old;
   logic [32:0] rq;
   logic [15:0] avg;
   logic [15:0] amax;
   logic [15:0] bmin;
   logic signed [16:0] diff;
   logic signed [16:0] dx;
   logic [16:0] trial;
   logic [16:0] nroot;
   logic [3:0] ty;
   logic [15:0] v;

   always_comb begin
      n = r;
      c = r.ch;
      bc = WB_ADR_I[7:6];
      bidx = WB_ADR_I[5:2];
      wdat = '0;
      irq_clr = '0;
      irq_ev = '0;
      dconf = 1'b0;
      nlen = 8'h01;
      xin = '0;
      old = '0;
      rq = '0;
      avg = '0;
      amax = '0;
      bmin = '0;
      diff = '0;
      dx = '0;
      trial = '0;
      nroot = '0;
      ty = '0;
      v = '0;

      // Millisecond time base for all timers
      n.tick = 1'b0;
      if (r.tick_cnt >= MS_CYCLES - 16'h0001) begin
         n.tick_cnt = '0;
         n.tick = 1'b1;
      end else begin
         n.tick_cnt = r.tick_cnt + 16'h0001;
      end

      for (int ci = 0; ci < 4; ci++) begin
         if (!r.disc_raw[ci]) begin
            n.disc_cnt[ci] = '0;
         end else if (r.tick && r.disc_cnt[ci] != 13'h1fff) begin
            n.disc_cnt[ci] = r.disc_cnt[ci] + 13'h0001;
         end
         if (r.tick && r.rate_cnt[ci] != 14'h3fff) begin
            n.rate_cnt[ci] = r.rate_cnt[ci] + 14'h0001;
         end
         for (int k = 0; k < 6; k++) begin
            v = (k < 4) ? r.pv[ci] : r.rate[ci];
            if (alm_want(v, r.sp[ci][k], r.hys[ci], k == 0 || k == 1 || k == 4,
                  r.alm[ci][k]) == r.alm[ci][k]) begin
               n.alm_cnt[ci][k] = '0;
            end else if (r.alm_cnt[ci][k] >=
                  16'(32'(r.dly[ci]) * pvc_pkg::MS_PER_S)) begin
               n.alm[ci][k] = ~r.alm[ci][k];
               n.alm_cnt[ci][k] = '0;
            end else if (r.tick) begin
               n.alm_cnt[ci][k] = r.alm_cnt[ci][k] + 16'h0001;
            end
         end
         irq_ev[4 + ci] = |(n.alm[ci] & ~r.alm[ci]);
      end

      // ========================================================
      // Sample pipeline; one sample at a time, arrivals while busy dropped
      case (r.st)
         pvc_pkg::ST_IDLE: begin
            if (SMP.valid) begin
               c = SMP.ch;
               ty = r.cfg[c].in_type;
               n.disc_raw[c] = SMP.disc;
               dconf = SMP.disc && (r.disc_cnt[c] >= disc_lim(ty));
               xin = dconf ? clamp_val(ty, r.cfg[c].clamp_hi) : SMP.value;
               n.fault[c] = dconf || range_fault(ty, SMP.value);
               irq_ev[c] = n.fault[c] && !r.fault[c];
               nlen = {1'b0, r.cfg[c].avg_nm1} + 8'h01;
               old = r.hist[c][r.wp[c] - nlen[6:0]];
               n.sum[c] = r.sum[c] + {{8{xin[15]}}, xin}
                  - {{8{old[15]}}, old};
               n.hist[c][r.wp[c]] = xin;
               n.wp[c] = r.wp[c] + 7'h01;
               n.ch = c;
               n.neg = n.sum[c][23];
               n.quo = n.sum[c][23] ? 24'h000000 - n.sum[c] : n.sum[c];
               n.rem = '0;
               n.itr = '0;
               n.st = pvc_pkg::ST_DIV;
            end
         end
         pvc_pkg::ST_DIV: begin
            nlen = {1'b0, r.cfg[c].avg_nm1} + 8'h01;
            rq = {r.rem, r.quo} << 1;
            if (rq[32:24] >= {1'b0, nlen}) begin
               rq[32:24] = rq[32:24] - {1'b0, nlen};
               rq[0] = 1'b1;
            end
            n.rem = rq[32:24];
            n.quo = rq[23:0];
            n.itr = r.itr + 5'h01;
            if (r.itr == 5'h17) begin
               avg = r.neg ? 16'h0000 - rq[15:0] : rq[15:0];
               ty = r.cfg[c].in_type;
               amax = r.scale[c][15:0];
               bmin = r.scale[c][31:16];
               diff = $signed({amax[15], amax}) - $signed({bmin[15], bmin});
               dx = $signed({avg[15], avg}) - $signed({bmin[15], bmin});
               n.x = avg;
               n.st = pvc_pkg::ST_POST;
               // Root only for DC inputs with max above min, outside dropout
               if (r.cfg[c].sqrt_en && (ty == pvc_pkg::IN_MV100 ||
                     ty >= pvc_pkg::IN_MA4_20) && sgt(amax, bmin) &&
                     34'(dx) * 34'(pvc_pkg::PCT_DEN) >
                     34'(diff) * 34'(pvc_pkg::DROP_PCT)) begin
                  n.rad = 34'(diff) * 34'(dx);
                  n.root = '0;
                  n.itr = 5'h10;
                  n.st = pvc_pkg::ST_SQRT;
               end
            end
         end
         pvc_pkg::ST_SQRT: begin
            trial = r.root | (17'h00001 << r.itr);
            nroot = r.root;
            if (34'(trial) * 34'(trial) <= r.rad) begin
               nroot = trial;
            end
            n.root = nroot;
            n.itr = r.itr - 5'h01;
            if (r.itr == 5'h00) begin
               n.x = nroot[15:0] + r.scale[c][31:16];
               n.st = pvc_pkg::ST_POST;
            end
         end
         pvc_pkg::ST_POST: begin
            n.pv[c] = r.x;
            if (r.cfg[c].rate_ivl == 5'h00) begin
               n.rate[c] = r.x - r.ref_pv[c];
               n.ref_pv[c] = r.x;
            end else if (r.rate_cnt[c] >=
                  14'(32'(r.cfg[c].rate_ivl) * pvc_pkg::MS_PER_S)) begin
               n.rate[c] = r.x - r.ref_pv[c];
               n.ref_pv[c] = r.x;
               n.rate_cnt[c] = '0;
            end
            n.st = pvc_pkg::ST_IDLE;
         end
         default: begin
            n.st = pvc_pkg::ST_IDLE;
         end
      endcase
      irq_ev[pvc_pkg::IRQ_OVR_BIT] = SMP.valid && r.st != pvc_pkg::ST_IDLE;

      // ========================================================
      // Wishbone slave: one ack per request, unmapped reads zero
      n.ack = 1'b0;
      wb_go = WB_CYC_I && WB_STB_I && !r.ack;
      if (wb_go) begin
         n.ack = 1'b1;
         n.rdat = '0;
         if (WB_ADR_I == pvc_pkg::IRQ_STAT_ADR) begin
            n.rdat = 32'(r.irq_stat);
            if (WB_WE_I) begin
               irq_clr = 9'(bmerge(32'h0, WB_DAT_I, WB_SEL_I));
            end
         end else if (WB_ADR_I == pvc_pkg::IRQ_MASK_ADR) begin
            n.rdat = 32'(r.irq_mask);
            if (WB_WE_I) begin
               n.irq_mask = 9'(bmerge(32'(r.irq_mask), WB_DAT_I, WB_SEL_I));
            end
         end else if (WB_ADR_I[11:8] == pvc_pkg::CH_PAGE) begin
            if (WB_ADR_I[5:0] == pvc_pkg::OFS_CFG) begin
               n.rdat = r.cfg[bc];
               if (WB_WE_I) begin
                  wdat = bmerge(r.cfg[bc], WB_DAT_I, WB_SEL_I)
                     & pvc_pkg::CFG_WMASK;
                  n.cfg[bc] = wdat;
                  if (n.cfg[bc].rate_ivl > 5'(pvc_pkg::IVL_MAX_S)) begin
                     n.cfg[bc].rate_ivl = 5'(pvc_pkg::IVL_MAX_S);
                  end
                  // A new window length restarts the average from zero,
                  // otherwise the running sum would mix two lengths
                  if (n.cfg[bc].avg_nm1 != r.cfg[bc].avg_nm1) begin
                     n.hist[bc] = '0;
                     n.sum[bc] = '0;
                     n.wp[bc] = '0;
                  end
               end
            end else if (WB_ADR_I[5:0] == pvc_pkg::OFS_SCALE) begin
               n.rdat = r.scale[bc];
               if (WB_WE_I) begin
                  n.scale[bc] = bmerge(r.scale[bc], WB_DAT_I, WB_SEL_I);
               end
            end else if (WB_ADR_I[5:0] >= pvc_pkg::OFS_SP0 &&
                  WB_ADR_I[5:0] <= pvc_pkg::OFS_SP5) begin
               n.rdat = {16'h0000, r.sp[bc][bidx - 4'h2]};
               if (WB_WE_I) begin
                  wdat = bmerge(n.rdat, WB_DAT_I, WB_SEL_I);
                  n.sp[bc][bidx - 4'h2] = wdat[15:0];
               end
            end else if (WB_ADR_I[5:0] == pvc_pkg::OFS_HYS) begin
               n.rdat = {10'h000, r.dly[bc], r.hys[bc]};
               if (WB_WE_I) begin
                  wdat = bmerge(n.rdat, WB_DAT_I, WB_SEL_I);
                  n.hys[bc] = wdat[15:0];
                  n.dly[bc] = (wdat[21:16] > 6'(pvc_pkg::DLY_MAX_S)) ?
                     6'(pvc_pkg::DLY_MAX_S) : wdat[21:16];
               end
            end else if (WB_ADR_I[5:0] == pvc_pkg::OFS_PV) begin
               n.rdat = {16'h0000, r.pv[bc]};
            end else if (WB_ADR_I[5:0] == pvc_pkg::OFS_RATE) begin
               n.rdat = {16'h0000, r.rate[bc]};
            end else if (WB_ADR_I[5:0] == pvc_pkg::OFS_STAT) begin
               n.rdat = {24'h000000, r.alm[bc], r.disc_raw[bc], r.fault[bc]};
            end
         end
      end

      // Events set after the clear so a same-cycle event is kept
      n.irq_stat = (r.irq_stat & ~irq_clr) | irq_ev;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         r <= '0;
         r.st <= pvc_pkg::ST_IDLE;
         r.cfg <= {4{pvc_pkg::CFG_RST}};
         r.scale <= {4{pvc_pkg::SCALE_RST}};
         r.sp <= {4{pvc_pkg::SP_LO_RST, pvc_pkg::SP_HI_RST,
            pvc_pkg::SP_LO_RST, pvc_pkg::SP_LO_RST,
            pvc_pkg::SP_HI_RST, pvc_pkg::SP_HI_RST}};
      end else if (CE) begin
         r <= n;
      end
   end

   assign WB_DAT_O = r.rdat;
   assign WB_ACK_O = r.ack;
   assign CH_FAULT = r.fault;
   assign IRQ = |(r.irq_stat & r.irq_mask);

endmodule : pvc_top

// ==== sim/pvc_chk.sv ====
// Checker: port-level properties of the conditioning block
module pvc_chk #(
   parameter logic [15:0] MS_CYCLES = 16'h0004
) (
   // Clock and control
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic CE,
   // Bus
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   // Samples and status
   input wire pvc_pkg::pvc_smp_t SMP,
   input wire logic [3:0] CH_FAULT,
   input wire logic IRQ
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);
   logic [3:0] oth;
   // Channels other than the one being sampled
   assign oth = ~(4'h1 << SMP.ch);
   // ==========================================================
   // Sequences
   sequence s_req;
      CE && WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   // In range for every input type, bipolar included
   sequence s_smp_in;
      CE && SMP.valid && !SMP.disc && !SMP.value[15] && SMP.value <= 16'h29fe;
   endsequence
   // ==========================================================
   // Properties
   property p_ack_lat;
      s_req |=> WB_ACK_O;
   endproperty
   property p_ack_pulse;
      WB_ACK_O && CE |=> !WB_ACK_O;
   endproperty
   property p_ack_req;
      $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I);
   endproperty
   property p_dat_hold;
      !WB_ACK_O |-> $stable(WB_DAT_O);
   endproperty
   property p_ce_freeze;
      !CE |=> $stable(CH_FAULT) && $stable(IRQ) && !$rose(WB_ACK_O);
   endproperty
   property p_range_hi;
      CE && SMP.valid && !SMP.value[15] && SMP.value > 16'h2cec
         |=> CH_FAULT[$past(SMP.ch)];
   endproperty
   property p_fault_clr;
      s_smp_in |=> !CH_FAULT[$past(SMP.ch)];
   endproperty
   property p_other;
      SMP.valid |=> (CH_FAULT & $past(oth)) == ($past(CH_FAULT) & $past(oth));
   endproperty
   a_ack_lat: assert property (p_ack_lat)
      else $error("ack not given one cycle after request");
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   a_ack_req: assert property (p_ack_req)
      else $error("ack without request");
   a_dat_hold: assert property (p_dat_hold)
      else $error("read data changed without ack");
   a_ce_freeze: assert property (p_ce_freeze)
      else $error("state moved while enable low");
   a_range_hi: assert property (p_range_hi)
      else $error("fault missing above upper limit");
   a_fault_clr: assert property (p_fault_clr)
      else $error("fault kept on in-range sample");
   a_other: assert property (p_other)
      else $error("fault of another channel changed");
endmodule : pvc_chk
bind pvc_top pvc_chk #(.MS_CYCLES(MS_CYCLES)) pvc_chk_inst (
   .CORE_CLK(CORE_CLK), .RST(RST), .CE(CE), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .SMP(SMP), .CH_FAULT(CH_FAULT), .IRQ(IRQ)
);

// ==== sim/pvc_cpu.sv ====
// Partner: controller-side master reaching the shared register area
module pvc_cpu (
   // Clock
   input wire logic clk,
   // Bus master side
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [11:0] adr,
   output logic [3:0] sel,
   output logic [31:0] dat,
   input wire logic [31:0] rdat,
   input wire logic ack
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = '0;
      sel = '0;
      dat = '0;
   end
   // Request held until ack is sampled; the next call idles one cycle
   task automatic xfer(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      dat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 200);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1) begin
         tb.chk("bus_ack", 32'h1, 32'h0);
         tb.end_of_test();
      end
   endtask : xfer
endmodule : pvc_cpu

// ==== sim/tb.sv ====
// Testbench: table-driven and hand-written checks of the conditioning block
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [31:0] cfg;
      logic [31:0] scale;
      logic [15:0] val;
      logic flt;
      logic [15:0] pv;
   } pvc_row_t;
   logic clk, rst, ce, wb_cyc, wb_stb, wb_we, wb_ack, irq;
   logic [11:0] wb_adr;
   logic [3:0] wb_sel, ch_fault;
   logic [31:0] wb_dati, wb_dato, q;
   pvc_pkg::pvc_smp_t smp;
   int n_fail = 0;
   int comparisons = 0;
   pvc_row_t rows [10] = '{
      '{32'h2, 32'h2710, 16'h2ced, 1'b1, 16'h2ced},
      '{32'h2, 32'h2710, 16'h2cec, 1'b0, 16'h2cec},
      '{32'h5, 32'h2710, 16'hfa23, 1'b1, 16'hfa23},
      '{32'h8, 32'h2710, 16'hfa23, 1'b0, 16'hfa23},
      '{32'h9, 32'h2710, 16'hfd11, 1'b1, 16'hfd11},
      '{32'h9, 32'h2710, 16'h29fe, 1'b0, 16'h29fe},
      '{32'h25, 32'h2710, 16'h09c4, 1'b0, 16'h1388},
      '{32'h25, 32'h2710, 16'h01f4, 1'b0, 16'h01f4},
      '{32'h22, 32'h2710, 16'h09c4, 1'b0, 16'h09c4},
      '{32'h25, 32'h2000_1000, 16'h09c4, 1'b0, 16'h09c4}};
   logic [31:0] dcfg [7] = '{32'h10, 32'h0, 32'h5, 32'h7, 32'h8, 32'h9,
      32'h3};
   logic [15:0] dpv [7] = '{pvc_pkg::PCT_P115, pvc_pkg::PCT_M15,
      pvc_pkg::PCT_M15, 16'h0000,
      16'h0000, pvc_pkg::PCT_MID, pvc_pkg::PCT_M15};
   // Disconnected samples per case; confirmation lands after the early check
   int dn [7] = '{25, 25, 25, 25, 25, 25, 45};
   // ==========================================================
   // Design and partner
   pvc_top #(.MS_CYCLES(16'h0004)) pvc_top_inst (
      .CORE_CLK(clk), .RST(rst), .CE(ce), .WB_CYC_I(wb_cyc),
      .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr),
      .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dati), .WB_DAT_O(wb_dato),
      .WB_ACK_O(wb_ack), .SMP(smp), .CH_FAULT(ch_fault), .IRQ(irq));
   pvc_cpu pvc_cpu_inst (.clk(clk), .cyc(wb_cyc), .stb(wb_stb),
      .we(wb_we), .adr(wb_adr), .sel(wb_sel), .dat(wb_dati),
      .rdat(wb_dato), .ack(wb_ack));
   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic end_of_test();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test
   function automatic logic [11:0] ca(input logic [1:0] c,
         input logic [5:0] o);
      return {pvc_pkg::CH_PAGE, c, o};
   endfunction : ca
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      pvc_cpu_inst.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [11:0] a);
      pvc_cpu_inst.xfer(1'b0, a, 32'h0, q);
   endtask : rd
   // Waits out the longest pipeline walk before anything is read
   task automatic send(input logic [1:0] c, input logic d,
         input logic [15:0] v);
      @(posedge clk);
      smp <= '{valid: 1'b1, ch: c, disc: d, value: v};
      @(posedge clk);
      smp.valid <= 1'b0;
      smp.value <= ~v;
      repeat (45) @(posedge clk);
   endtask : send
   task automatic hh_at(input int w, input logic e);
      repeat (w) @(posedge clk);
      rd(ca(2'h3, pvc_pkg::OFS_STAT));
      chk("hh_alarm", {31'h0, e}, {31'h0, q[2]});
   endtask : hh_at
   // ==========================================================
   // Stimulus
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      smp = '0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("fault", 32'h0, {28'h0, ch_fault});
      chk("irq", 32'h0, {31'h0, irq});
      ce <= 1'b0;
      repeat (4) @(posedge clk);
      ce <= 1'b1;
      rd(pvc_pkg::IRQ_MASK_ADR);
      chk("irq_mask", 32'h0, q);
      rd(ca(2'h0, pvc_pkg::OFS_CFG));
      chk("cfg", pvc_pkg::CFG_RST, q);
      rd(ca(2'h3, pvc_pkg::OFS_SCALE));
      chk("scale", pvc_pkg::SCALE_RST, q);
      rd(ca(2'h1, pvc_pkg::OFS_SP0));
      chk("sp_hh", {16'h0, pvc_pkg::SP_HI_RST}, q);
      rd(ca(2'h1, 6'h10));
      chk("sp_ll", {16'h0, pvc_pkg::SP_LO_RST}, q);
      rd(ca(2'h1, 6'h18));
      chk("sp_rh", {16'h0, pvc_pkg::SP_HI_RST}, q);
      wr(12'h080, 32'hffff_ffff);
      rd(12'h080);
      chk("unmapped", 32'h0, q);
      foreach (rows[i]) begin
         wr(ca(2'h2, pvc_pkg::OFS_CFG), rows[i].cfg);
         wr(ca(2'h2, pvc_pkg::OFS_SCALE), rows[i].scale);
         send(2'h2, 1'b0, rows[i].val);
         chk("fault", {31'h0, rows[i].flt}, {31'h0, ch_fault[2]});
         rd(ca(2'h2, pvc_pkg::OFS_PV));
         chk("pv", {16'h0, rows[i].pv}, q);
      end
      rd(pvc_pkg::IRQ_STAT_ADR);
      chk("irq_stat", 32'h4, q);
      chk("irq", 32'h0, {31'h0, irq});
      wr(pvc_pkg::IRQ_MASK_ADR, 32'h1ff);
      chk("irq", 32'h1, {31'h0, irq});
      wr(pvc_pkg::IRQ_STAT_ADR, 32'h4);
      chk("irq", 32'h0, {31'h0, irq});
      // Second sample while busy must be refused as overrun
      @(posedge clk);
      smp <= '{valid: 1'b1, ch: 2'h0, disc: 1'b0, value: 16'h0100};
      repeat (2) @(posedge clk);
      smp.valid <= 1'b0;
      repeat (45) @(posedge clk);
      rd(pvc_pkg::IRQ_STAT_ADR);
      chk("irq_stat", 32'h100, q);
      wr(pvc_pkg::IRQ_STAT_ADR, 32'h100);
      chk("irq", 32'h0, {31'h0, irq});
      wr(ca(2'h1, pvc_pkg::OFS_CFG), 32'h0001_0005);
      send(2'h1, 1'b0, 16'h03e8);
      send(2'h1, 1'b0, 16'h0bb8);
      rd(ca(2'h1, pvc_pkg::OFS_PV));
      chk("pv_avg", 32'h07d0, q);
      send(2'h1, 1'b0, 16'h0bb8);
      rd(ca(2'h1, pvc_pkg::OFS_RATE));
      chk("rate", 32'h03e8, q);
      wr(ca(2'h3, pvc_pkg::OFS_CFG), 32'h5);
      wr(ca(2'h3, pvc_pkg::OFS_SP0), 32'h1f40);
      wr(ca(2'h3, pvc_pkg::OFS_HYS), 32'h0001_0064);
      send(2'h3, 1'b0, 16'h2328);
      hh_at(3000, 1'b0);
      hh_at(1200, 1'b1);
      send(2'h3, 1'b0, 16'h1f0e);
      hh_at(4200, 1'b1);
      send(2'h3, 1'b0, 16'h1e00);
      hh_at(3000, 1'b1);
      hh_at(1200, 1'b0);
      foreach (dcfg[k]) begin
         wr(ca(2'h0, pvc_pkg::OFS_CFG), dcfg[k]);
         send(2'h0, 1'b0, 16'h1000);
         for (int i = 0; i < dn[k]; i++) begin
            send(2'h0, 1'b1, 16'h1000);
            repeat (54) @(posedge clk);
            if (i == dn[k] - 7) begin
               chk("disc_fault", 32'h0, {31'h0, ch_fault[0]});
            end
         end
         chk("disc_fault", 32'h1, {31'h0, ch_fault[0]});
         rd(ca(2'h0, pvc_pkg::OFS_PV));
         chk("disc_pv", {16'h0, dpv[k]}, q);
      end
      // Reset in mid-run clears flags, interrupt and mask
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk("fault", 32'h0, {28'h0, ch_fault});
      chk("irq", 32'h0, {31'h0, irq});
      rst <= 1'b0;
      @(posedge clk);
      rd(pvc_pkg::IRQ_MASK_ADR);
      chk("irq_mask", 32'h0, q);
      end_of_test();
   end
endmodule : tb
